// >>> hdl/line_measurement_map.vh
// register offsets, field positions, reset values and port timing for the line readout
`ifndef LINE_MEASUREMENT_MAP_VH
`define LINE_MEASUREMENT_MAP_VH

// =====================================================================
// register offsets on the serial control port
`define LOOP_VOLTAGE_MONITOR_ADDR 7'h4e
`define LOOP_CURRENT_MONITOR_ADDR 7'h4f
`define TIP_VOLTAGE_MONITOR_ADDR 7'h50
`define RING_VOLTAGE_MONITOR_ADDR 7'h51
`define BATTERY_VOLTAGE_MONITOR_A_ADDR 7'h52
`define BATTERY_VOLTAGE_MONITOR_B_ADDR 7'h53
`define FIRST_TRANSISTOR_CURRENT_MONITOR_ADDR 7'h54
`define SECOND_TRANSISTOR_CURRENT_MONITOR_ADDR 7'h55

// =====================================================================
// field positions in the loop registers
`define LOOP_SIGN_BIT 6
`define LOOP_MAG_MSB 5
`define LOOP_MAG_LSB 0

// =====================================================================
// reset values
`define MONITOR_RESET_VALUE 8'h00
`define LOOP_MAG_RESET_VALUE 6'h00

// =====================================================================
// control byte layout and frame timing in serial clock edges
`define CTRL_READ_BIT 7
`define CTRL_BITS 4'h8
`define FRAME_BITS 5'h10
`define UNMAPPED_READ_VALUE 8'h00

`endif

// >>> hdl/line_measurement_readout.v
// read-only line measurement monitor registers behind the serial control port
`timescale 1ns/10ps
`default_nettype none
`include "line_measurement_map.vh"

module line_measurement_readout (
    input wire clk,
    input wire rst,
    // serial control port, sampled on clk
    input wire sclk,
    input wire cs_n,
    input wire sdi,
    output reg sdo,
    output reg sdo_oe,
    // measurement codes from the analog path
    input wire loop_voltage_sign,
    input wire [5:0] loop_voltage_magnitude,
    input wire loop_current_sign,
    input wire [5:0] loop_current_magnitude,
    input wire [7:0] tip_voltage_level,
    input wire [7:0] ring_voltage_level,
    input wire [7:0] battery_voltage_level_a,
    input wire [7:0] battery_voltage_level_b,
    input wire [7:0] first_transistor_current,
    input wire [7:0] second_transistor_current,
    input wire extended_battery_enable,
    input wire [7:0] extended_battery_offset
);

    // =====================================================================
    // helpers

    // current with the extended battery offset removed, floored at zero
    function [7:0] strip_offset;
        input [7:0] raw;
        input [7:0] offset;
        input enable;
        begin
            if (!enable)
            begin
                strip_offset = raw;
            end
            else if (raw > offset)
            begin
                strip_offset = raw - offset;
            end
            else
            begin
                strip_offset = 8'h00;
            end
        end
    endfunction

    // loop reading byte: reserved top bit zero, then sign, then magnitude
    function [7:0] pack_loop_reading;
        input sign_bit;
        input [5:0] magnitude;
        begin
            pack_loop_reading = 8'h00;
            pack_loop_reading[`LOOP_SIGN_BIT] = sign_bit;
            pack_loop_reading[`LOOP_MAG_MSB:`LOOP_MAG_LSB] = magnitude;
        end
    endfunction

    // =====================================================================
    // monitor registers

    reg loop_voltage_sign_reg;
    reg [5:0] loop_voltage_magnitude_reg;
    reg loop_current_sign_reg;
    reg [5:0] loop_current_magnitude_reg;
    reg [7:0] tip_voltage_reg;
    reg [7:0] ring_voltage_reg;
    reg [7:0] battery_a_reg;
    reg [7:0] battery_b_reg;
    reg [7:0] first_current_reg;
    reg [7:0] second_current_reg;

    // realtime capture of every measurement, refreshed each clock
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            loop_voltage_sign_reg <= 1'b0;
            loop_voltage_magnitude_reg <= `LOOP_MAG_RESET_VALUE;
            loop_current_sign_reg <= 1'b0;
            loop_current_magnitude_reg <= `LOOP_MAG_RESET_VALUE;
            tip_voltage_reg <= `MONITOR_RESET_VALUE;
            ring_voltage_reg <= `MONITOR_RESET_VALUE;
            battery_a_reg <= `MONITOR_RESET_VALUE;
            battery_b_reg <= `MONITOR_RESET_VALUE;
            first_current_reg <= `MONITOR_RESET_VALUE;
            second_current_reg <= `MONITOR_RESET_VALUE;
        end
        else
        begin
            loop_voltage_sign_reg <= loop_voltage_sign;
            loop_voltage_magnitude_reg <= loop_voltage_magnitude;
            loop_current_sign_reg <= loop_current_sign;
            loop_current_magnitude_reg <= loop_current_magnitude;
            tip_voltage_reg <= tip_voltage_level;
            ring_voltage_reg <= ring_voltage_level;
            battery_a_reg <= battery_voltage_level_a;
            battery_b_reg <= battery_voltage_level_b;
            first_current_reg <= strip_offset(first_transistor_current,
                extended_battery_offset, extended_battery_enable);
            second_current_reg <= strip_offset(second_transistor_current,
                extended_battery_offset, extended_battery_enable);
        end
    end

    // =====================================================================
    // read decode

    reg [7:0] read_value;
    wire [6:0] addr_now;

    // read mux; unmapped addresses read zero
    always @*
    begin
        read_value = `UNMAPPED_READ_VALUE;
        if (addr_now == `LOOP_VOLTAGE_MONITOR_ADDR)
        begin
            read_value = pack_loop_reading(loop_voltage_sign_reg,
                loop_voltage_magnitude_reg);
        end
        else if (addr_now == `LOOP_CURRENT_MONITOR_ADDR)
        begin
            read_value = pack_loop_reading(loop_current_sign_reg,
                loop_current_magnitude_reg);
        end
        else if (addr_now == `TIP_VOLTAGE_MONITOR_ADDR)
        begin
            read_value = tip_voltage_reg;
        end
        else if (addr_now == `RING_VOLTAGE_MONITOR_ADDR)
        begin
            read_value = ring_voltage_reg;
        end
        else if (addr_now == `BATTERY_VOLTAGE_MONITOR_A_ADDR)
        begin
            read_value = battery_a_reg;
        end
        else if (addr_now == `BATTERY_VOLTAGE_MONITOR_B_ADDR)
        begin
            read_value = battery_b_reg;
        end
        else if (addr_now == `FIRST_TRANSISTOR_CURRENT_MONITOR_ADDR)
        begin
            read_value = first_current_reg;
        end
        else if (addr_now == `SECOND_TRANSISTOR_CURRENT_MONITOR_ADDR)
        begin
            read_value = second_current_reg;
        end
    end

    // =====================================================================
    // serial control port

    // frame phases
    localparam [1:0] FRAME_IDLE = 2'b00;
    localparam [1:0] FRAME_CTRL = 2'b01;
    localparam [1:0] FRAME_READ = 2'b10;
    localparam [1:0] FRAME_WRITE = 2'b11;

    reg sclk_prev_reg;
    reg [4:0] bit_count_reg;
    reg [6:0] ctrl_shift_reg;
    reg [1:0] frame_state_reg;
    reg [1:0] frame_state_next;
    reg [7:0] tx_shift_reg;

    wire sclk_rise;
    wire sclk_fall;
    wire ctrl_done;
    wire frame_full;

    // serial clock edges as seen on clk; sclk idles low, so no false edge after reset
    assign sclk_rise = sclk & ~sclk_prev_reg;
    assign sclk_fall = ~sclk & sclk_prev_reg;
    // last control bit arriving on this rising edge
    assign ctrl_done = sclk_rise && (bit_count_reg == {1'b0, `CTRL_BITS} - 5'h01);
    // bits past the data byte are ignored
    assign frame_full = (bit_count_reg == `FRAME_BITS);
    assign addr_now = {ctrl_shift_reg[5:0], sdi};

    // previous serial clock level for edge detection
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            sclk_prev_reg <= sclk;
        end
    end

    // frame phase: control byte first, then a read or a write data byte
    always @*
    begin
        frame_state_next = frame_state_reg;
        case (frame_state_reg)
            FRAME_IDLE:
            begin
                frame_state_next = FRAME_CTRL;
            end
            FRAME_CTRL:
            begin
                if (ctrl_done && ctrl_shift_reg[`CTRL_READ_BIT - 1])
                begin
                    frame_state_next = FRAME_READ;
                end
                else if (ctrl_done)
                begin
                    frame_state_next = FRAME_WRITE;
                end
            end
            FRAME_READ:
            begin
                frame_state_next = FRAME_READ;
            end
            FRAME_WRITE:
            begin
                frame_state_next = FRAME_WRITE;
            end
            default:
            begin
                frame_state_next = FRAME_IDLE;
            end
        endcase
        // deselect abandons the frame in any phase
        if (cs_n)
        begin
            frame_state_next = FRAME_IDLE;
        end
    end

    // bit counter, control shift and frame phase
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            bit_count_reg <= 5'h00;
            ctrl_shift_reg <= 7'h00;
            frame_state_reg <= FRAME_IDLE;
        end
        else
        begin
            frame_state_reg <= frame_state_next;
            if (cs_n)
            begin
                bit_count_reg <= 5'h00;
            end
            else if (sclk_rise && !frame_full)
            begin
                bit_count_reg <= bit_count_reg + 5'h01;
                ctrl_shift_reg <= {ctrl_shift_reg[5:0], sdi};
            end
        end
    end

    // read data out: snapshot at control end, one bit per falling serial edge
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_shift_reg <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end
        else if (cs_n)
        begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end
        else
        begin
            // snapshot whole byte so a reading cannot tear mid-shift
            if (ctrl_done)
            begin
                tx_shift_reg <= read_value;
            end
            // write frames never drive, so their data bits are dropped
            if (sclk_fall && frame_state_reg == FRAME_READ)
            begin
                sdo <= tx_shift_reg[7];
                sdo_oe <= 1'b1;
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end

endmodule

`default_nettype wire

// >>> tb/serial_host_model.sv
// host model that drives frames on the serial control port
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
    input wire logic clk,
    input wire logic sdo,
    output var logic sclk = 1'b0,
    output var logic cs_n = 1'b1,
    output var logic sdi = 1'b0
);
    // one 16-bit frame, msb first, sdo taken just before each rise
    task xfer(input logic [15:0] w, output logic [7:0] rd);
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge clk) sdi <= w[i];
            repeat (2) @(posedge clk);
            rd = {rd[6:0], sdo};
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        sdi <= ~w[0]; // released line shows no stale bit
    endtask
endmodule
`default_nettype wire

// >>> tb/line_measurement_readout_monitor.sv
// assertions on the readout serial port answers
`timescale 1ns/10ps
`default_nettype none
module line_measurement_readout_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic [7:0] tip_voltage_level,
    input wire logic [7:0] first_transistor_current,
    input wire logic extended_battery_enable
);
    logic sclk_seen_reg;
    logic [4:0] bits_reg;
    logic [7:0] ctl_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // =====
    // frame decode: bit count and control byte, sampled as the port does
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sclk_seen_reg <= 1'b0;
            bits_reg <= 5'h00;
            ctl_reg <= 8'h00;
        end
        else
        begin
            sclk_seen_reg <= sclk;
            if (cs_n)
                bits_reg <= 5'h00;
            else if (sclk && !sclk_seen_reg && bits_reg < 5'h10)
            begin
                bits_reg <= bits_reg + 5'h01;
                if (bits_reg < 5'h08)
                    ctl_reg <= {ctl_reg[6:0], sdi};
            end
        end
    end
    // frame end as seen on cs_n
    sequence deselect;
        !cs_n ##1 cs_n;
    endsequence
    wr_quiet_a: assert property (bits_reg >= 5'h08 && !ctl_reg[7] |-> !sdo_oe)
        else $error("drive in write frame");
    desel_idle_a: assert property (deselect |=> !sdo_oe && !sdo)
        else $error("sdo left driven");
    oe_hold_a: assert property (sdo_oe && !cs_n |=> sdo_oe)
        else $error("sdo_oe dropped early");
    loop_top_a: assert property ($rose(sdo_oe) && ctl_reg[6:1] == 6'h27 |-> !sdo)
        else $error("loop top bit set");
    unmapped_zero_a: assert property ($rose(sdo_oe) && ctl_reg[6:0] > 7'h55 |-> !sdo)
        else $error("unmapped bit set");
    tip_msb_a: assert property ($rose(sdo_oe) && ctl_reg[6:0] == 7'h50 |->
        sdo == tip_voltage_level[7])
        else $error("tip msb wrong");
    current_msb_a: assert property ($rose(sdo_oe) && ctl_reg[6:0] == 7'h54 &&
        !extended_battery_enable |-> sdo == first_transistor_current[7])
        else $error("current msb wrong");
    offset_removed_a: assert property ($rose(sdo_oe) && ctl_reg[6:0] == 7'h54 &&
        extended_battery_enable |-> !sdo || first_transistor_current[7])
        else $error("offset added");
endmodule
bind line_measurement_readout line_measurement_readout_monitor mon (.clk, .rst, .sclk, .cs_n,
    .sdi, .sdo, .sdo_oe, .tip_voltage_level, .first_transistor_current, .extended_battery_enable);
`default_nettype wire

// >>> tb/test_line_measurement_readout.sv
// self-checking bench of the line measurement readout
`timescale 1ns/10ps
`default_nettype none
module test_line_measurement_readout;
    // =====
    // stimulus, counters and wiring
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ebe = 1'b0;
    logic [7:0] off = 8'h00;
    logic [7:0] v, e;
    logic [7:0] m [0:7] = '{default: 8'h00};
    wire sclk, cs_n, sdi, sdo, sdo_oe;
    integer failures = 0;
    integer n_compared = 0;
    line_measurement_readout uut (.clk, .rst, .sclk, .cs_n, .sdi, .sdo, .sdo_oe,
        .loop_voltage_sign(m[0][6]), .loop_voltage_magnitude(m[0][5:0]),
        .loop_current_sign(m[1][6]), .loop_current_magnitude(m[1][5:0]),
        .tip_voltage_level(m[2]), .ring_voltage_level(m[3]),
        .battery_voltage_level_a(m[4]), .battery_voltage_level_b(m[5]),
        .first_transistor_current(m[6]), .second_transistor_current(m[7]),
        .extended_battery_enable(ebe), .extended_battery_offset(off));
    serial_host_model host (.clk, .sdo, .sclk, .cs_n, .sdi);
    // 200 MHz clock
    initial
        forever #2.5 clk = ~clk;
    // compare one register value
    task check(input logic [6:0] a, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch reg %h exp %h seen %h", a, exp, seen);
        end
    endtask
    // one read frame
    task rd(input logic [6:0] a, input logic [7:0] exp);
        host.xfer({1'b1, a, 8'h00}, v);
        check(a, v, exp);
    endtask
    // verdict and stop
    task end_sim;
        if (failures == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // full scale, zero, then a mixed pattern with offset removal on
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int s = 0; s < 3; s++)
        begin
            for (int k = 0; k < 8; k++)
                m[k] <= s == 0 ? 8'hff : s == 1 ? 8'h00 : 8'h5a ^ k[7:0];
            ebe <= s == 2;
            off <= 8'h5c;
            repeat (2) @(posedge clk);
            for (int k = 0; k < 8; k++)
            begin
                e = m[k];
                if (k < 2)
                    e[7] = 1'b0;
                if (k > 5 && ebe)
                    e = m[k] > off ? m[k] - off : 8'h00;
                rd(7'h4e + k[6:0], e);
            end
        end
        // a write frame leaves the reading alone, unmapped reads zero
        host.xfer({1'b0, 7'h50, 8'h3c}, v);
        rd(7'h50, 8'h58);
        rd(7'h56, 8'h00);
        end_sim;
    end
endmodule
`default_nettype wire
